// ### include/fadcp_map.svh
// register offsets, field positions and codes of the fault address block
`ifndef FADCP_MAP_SVH
`define FADCP_MAP_SVH
`define FADCP_DEC_MSB     11
`define FADCP_OFF_MPFA    12'h000
`define FADCP_OFF_BFA     12'h004
`define FADCP_OFF_CPAC    12'h008
`define FADCP_OFF_STAT    12'h00C
`define FADCP_ST_MPV      0
`define FADCP_ST_BFV      1
`define FADCP_FP_PRI_LSB  20
`define FADCP_FP_SEC_LSB  22
`define FADCP_FP_NUM      4'hA
`define FADCP_CP_SEL_MSB  3
`define FADCP_NUM_CP      8
`define FADCP_NUM_BANK    2
`define FADCP_PROT_NS     1
`define FADCP_RESP_OKAY   2'h0
`define FADCP_RESP_SLVERR 2'h2
`define FADCP_ZERO32      32'h0000_0000
`define FADCP_SEL_SEC     2'h1
`define FADCP_SEL_NS      2'h2
`endif

// ### include/fadcp_pkg.sv
// types shared by the fault address and coprocessor access block
package fadcp_pkg;
    typedef enum logic [1:0] {
        PRIV_DENY     = 2'h0,
        PRIV_PRIVONLY = 2'h1,
        PRIV_RSVD     = 2'h2,
        PRIV_FULL     = 2'h3
    } fadcp_priv_t;

    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP    = 2'b10
    } fadcp_wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } fadcp_rd_state_t;
endpackage : fadcp_pkg

// ### core/fadcp_access_check.sv
// privilege decode of one coprocessor access-control word
`timescale 1ns/1ps
`include "fadcp_map.svh"
module fadcp_access_check
    import fadcp_pkg::*;
(
    input  wire logic [31:0] coproc_access_control_i,
    input  wire logic [3:0]  num_i,
    input  wire logic        priv_i,
    output logic             deny_o
);
    logic [`FADCP_NUM_CP-1:0] cp_deny;
    fadcp_priv_t              fp_field;

    // reserved codes behave like no access
    function automatic logic field_denies(input fadcp_priv_t f, input logic priv);
        field_denies = (f != PRIV_FULL) && !((f == PRIV_PRIVONLY) && priv);
    endfunction : field_denies

    genvar m;
    generate
        for (m = 0; m < `FADCP_NUM_CP; m++) begin : g_cp
            assign cp_deny[m] = field_denies(fadcp_priv_t'(coproc_access_control_i[2*m +: 2]), priv_i);
        end
    endgenerate

    // only the primary floating-point field is looked at
    assign fp_field = fadcp_priv_t'(coproc_access_control_i[`FADCP_FP_PRI_LSB +: 2]);

    always_comb begin
        if (num_i == `FADCP_FP_NUM) begin
            deny_o = field_denies(fp_field, priv_i);
        end else if (!num_i[`FADCP_CP_SEL_MSB]) begin
            deny_o = cp_deny[num_i[`FADCP_CP_SEL_MSB-1:0]];
        end else begin
            deny_o = 1'b1;
        end
    end
endmodule : fadcp_access_check

// ### core/fadcp_top.sv
// fault address capture and coprocessor access control with AXI4-Lite slave
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "fadcp_map.svh"
module fadcp_top
    import fadcp_pkg::*;
#(
    parameter bit       SEC_PRESENT = 1'b1,
    parameter bit       FP_PRESENT  = 1'b1,
    parameter bit [7:0] CP_IMPL     = 8'hFF
) (
    input  wire logic        MCLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        CE_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    input  wire logic [31:0] S_AXI_AWADDR_I,
    input  wire logic [2:0]  S_AXI_AWPROT_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    output logic [1:0]       S_AXI_BRESP_O,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    input  wire logic [31:0] S_AXI_ARADDR_I,
    input  wire logic [2:0]  S_AXI_ARPROT_I,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    input  wire logic        MPF_EVENT_I,
    input  wire logic [31:0] MPF_ADDR_I,
    input  wire logic        MPF_NS_I,
    input  wire logic        BF_EVENT_I,
    input  wire logic [31:0] BF_ADDR_I,
    input  wire logic        CP_REQ_I,
    input  wire logic [3:0]  CP_NUM_I,
    input  wire logic        CP_PRIV_I,
    input  wire logic        CP_NS_I,
    output logic             CP_FAULT_O
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    fadcp_wr_state_t wr_state_ff;
    fadcp_rd_state_t rd_state_ff;
    logic            aw_got_ff;
    logic            w_got_ff;
    logic [31:0]     awaddr_ff;
    logic            awns_ff;
    logic [31:0]     wdata_ff;
    logic [3:0]      wstrb_ff;
    logic [1:0]      bresp_ff;
    logic [31:0]     rdata_ff;
    logic [1:0]      rresp_ff;
    logic [31:0]     mpfa_ff  [`FADCP_NUM_BANK];
    logic [31:0]     coproc_access_control_ff [`FADCP_NUM_BANK];
    logic [1:0]      mpv_ff;
    logic [31:0]     bfa_ff;
    logic            bfv_ff;
    logic            cp_fault_ff;

    logic [31:0]                 cp_wmask;
    logic [`FADCP_DEC_MSB:0]     wr_off;
    logic [`FADCP_DEC_MSB:0]     rd_off;
    logic [1:0]                  wr_sel;
    logic [1:0]                  rd_sel;
    logic [1:0]                  mp_sel;
    logic [1:0]                  cp_sel;
    logic                        do_write;
    logic                        wr_ok;
    logic                        aw_hs;
    logic                        w_hs;
    logic                        ar_hs;
    logic                        nxt_rd_ok;
    logic [31:0]                 nxt_rdata;
    logic                        cp_deny;
    logic [31:0]                 wr_merged;

    function automatic logic [1:0] bank_sel(input logic ns);
        bank_sel = (SEC_PRESENT && ns) ? `FADCP_SEL_NS : `FADCP_SEL_SEC;
    endfunction : bank_sel

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction : merge

    // ------------------------------------------------------------
    // writable bits of the access-control word
    // ------------------------------------------------------------
    genvar m;
    generate
        for (m = 0; m < `FADCP_NUM_CP; m++) begin : g_mask
            assign cp_wmask[2*m +: 2] = {2{CP_IMPL[m]}};
        end
    endgenerate
    assign cp_wmask[`FADCP_FP_PRI_LSB-1:2*`FADCP_NUM_CP] = '0;
    assign cp_wmask[`FADCP_FP_SEC_LSB+1:`FADCP_FP_PRI_LSB] = {4{FP_PRESENT}};
    assign cp_wmask[31:`FADCP_FP_SEC_LSB+2] = '0;

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    assign S_AXI_AWREADY_O = CE_I && (wr_state_ff == WR_COLLECT) && !aw_got_ff;
    assign S_AXI_WREADY_O  = CE_I && (wr_state_ff == WR_COLLECT) && !w_got_ff;
    assign S_AXI_BVALID_O  = (wr_state_ff == WR_RESP);
    assign S_AXI_BRESP_O   = bresp_ff;
    assign aw_hs     = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
    assign w_hs      = S_AXI_WVALID_I && S_AXI_WREADY_O;
    assign do_write  = CE_I && (wr_state_ff == WR_COLLECT) && aw_got_ff && w_got_ff;
    assign wr_off    = awaddr_ff[`FADCP_DEC_MSB:0];
    assign wr_sel    = bank_sel(awns_ff);
    assign wr_ok     = (wr_off == `FADCP_OFF_MPFA) || (wr_off == `FADCP_OFF_BFA) ||
                       (wr_off == `FADCP_OFF_CPAC) || (wr_off == `FADCP_OFF_STAT);
    assign wr_merged = merge(`FADCP_ZERO32, wdata_ff, wstrb_ff);

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            aw_got_ff <= 1'b0;
            awaddr_ff <= `FADCP_ZERO32;
            awns_ff   <= 1'b0;
        end else if (CE_I) begin
            if (aw_hs) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= S_AXI_AWADDR_I;
                awns_ff   <= S_AXI_AWPROT_I[`FADCP_PROT_NS];
            end else if (do_write) begin
                aw_got_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            w_got_ff <= 1'b0;
            wdata_ff <= `FADCP_ZERO32;
            wstrb_ff <= 4'h0;
        end else if (CE_I) begin
            if (w_hs) begin
                w_got_ff <= 1'b1;
                wdata_ff <= S_AXI_WDATA_I;
                wstrb_ff <= S_AXI_WSTRB_I;
            end else if (do_write) begin
                w_got_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            wr_state_ff <= WR_COLLECT;
            bresp_ff    <= `FADCP_RESP_OKAY;
        end else if (CE_I) begin
            unique case (wr_state_ff)
                WR_COLLECT: begin
                    if (do_write) begin
                        wr_state_ff <= WR_RESP;
                        bresp_ff    <= wr_ok ? `FADCP_RESP_OKAY : `FADCP_RESP_SLVERR;
                    end
                end
                WR_RESP: begin
                    if (S_AXI_BREADY_I) begin
                        wr_state_ff <= WR_COLLECT;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // banked registers: memprot address, its flag, access control
    // ------------------------------------------------------------
    assign mp_sel = bank_sel(MPF_NS_I);

    genvar b;
    generate
        for (b = 0; b < `FADCP_NUM_BANK; b++) begin : g_bank
            always_ff @(posedge MCLK_I) begin
                if (!RST_N_I) begin
                    mpfa_ff[b]  <= `FADCP_ZERO32;
                    mpv_ff[b]   <= 1'b0;
                    coproc_access_control_ff[b] <= `FADCP_ZERO32;
                end else if (CE_I) begin
                    // core capture beats a software write in the same cycle
                    if (MPF_EVENT_I && mp_sel[b]) begin
                        mpfa_ff[b] <= MPF_ADDR_I;
                    end else if (do_write && wr_sel[b] && (wr_off == `FADCP_OFF_MPFA)) begin
                        mpfa_ff[b] <= merge(mpfa_ff[b], wdata_ff, wstrb_ff);
                    end
                    // set wins over write-one-to-clear
                    if (MPF_EVENT_I && mp_sel[b]) begin
                        mpv_ff[b] <= 1'b1;
                    end else if (do_write && wr_sel[b] && (wr_off == `FADCP_OFF_STAT) &&
                                 wr_merged[`FADCP_ST_MPV]) begin
                        mpv_ff[b] <= 1'b0;
                    end
                    if (do_write && wr_sel[b] && (wr_off == `FADCP_OFF_CPAC)) begin
                        coproc_access_control_ff[b] <= merge(coproc_access_control_ff[b], wdata_ff, wstrb_ff) & cp_wmask;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // shared bus fault address and its flag
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            bfa_ff <= `FADCP_ZERO32;
            bfv_ff <= 1'b0;
        end else if (CE_I) begin
            if (BF_EVENT_I) begin
                bfa_ff <= BF_ADDR_I;
            end else if (do_write && (wr_off == `FADCP_OFF_BFA)) begin
                bfa_ff <= merge(bfa_ff, wdata_ff, wstrb_ff);
            end
            if (BF_EVENT_I) begin
                bfv_ff <= 1'b1;
            end else if (do_write && (wr_off == `FADCP_OFF_STAT) && wr_merged[`FADCP_ST_BFV]) begin
                bfv_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    assign S_AXI_ARREADY_O = CE_I && (rd_state_ff == RD_IDLE);
    assign S_AXI_RVALID_O  = (rd_state_ff == RD_RESP);
    assign S_AXI_RDATA_O   = rdata_ff;
    assign S_AXI_RRESP_O   = rresp_ff;
    assign ar_hs  = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    assign rd_off = S_AXI_ARADDR_I[`FADCP_DEC_MSB:0];
    assign rd_sel = bank_sel(S_AXI_ARPROT_I[`FADCP_PROT_NS]);

    always_comb begin
        nxt_rd_ok = 1'b1;
        nxt_rdata = `FADCP_ZERO32;
        unique case (rd_off)
            `FADCP_OFF_MPFA: nxt_rdata = mpfa_ff[rd_sel[1]];
            `FADCP_OFF_BFA:  nxt_rdata = bfa_ff;
            `FADCP_OFF_CPAC: nxt_rdata = coproc_access_control_ff[rd_sel[1]] & cp_wmask;
            `FADCP_OFF_STAT: begin
                nxt_rdata[`FADCP_ST_MPV] = mpv_ff[rd_sel[1]];
                nxt_rdata[`FADCP_ST_BFV] = bfv_ff;
            end
            default:         nxt_rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            rd_state_ff <= RD_IDLE;
            rdata_ff    <= `FADCP_ZERO32;
            rresp_ff    <= `FADCP_RESP_OKAY;
        end else if (CE_I) begin
            unique case (rd_state_ff)
                RD_IDLE: begin
                    if (ar_hs) begin
                        rd_state_ff <= RD_RESP;
                        rdata_ff    <= nxt_rdata;
                        rresp_ff    <= nxt_rd_ok ? `FADCP_RESP_OKAY : `FADCP_RESP_SLVERR;
                    end
                end
                RD_RESP: begin
                    if (S_AXI_RREADY_I) begin
                        rd_state_ff <= RD_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // coprocessor access check
    // ------------------------------------------------------------
    assign cp_sel = bank_sel(CP_NS_I);

    fadcp_access_check u_check (
        .coproc_access_control_i (coproc_access_control_ff[cp_sel[1]]),
        .num_i   (CP_NUM_I),
        .priv_i  (CP_PRIV_I),
        .deny_o  (cp_deny)
    );

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            cp_fault_ff <= 1'b0;
        end else if (CE_I) begin
            cp_fault_ff <= CP_REQ_I && cp_deny;
        end
    end
    assign CP_FAULT_O = cp_fault_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);

    mpf_capture_a: assert property (
        CE_I && MPF_EVENT_I |=> (mpfa_ff[$past(mp_sel[1])] == $past(MPF_ADDR_I)) &&
                                mpv_ff[$past(mp_sel[1])])
        else $error("memprot address not captured");

    mpf_bank_split_a: assert property (
        SEC_PRESENT && CE_I && MPF_EVENT_I && MPF_NS_I && !do_write |=> $stable(mpfa_ff[0]))
        else $error("non-secure memprot fault touched secure copy");

    bf_capture_a: assert property (
        CE_I && BF_EVENT_I |=> (bfa_ff == $past(BF_ADDR_I)) && bfv_ff)
        else $error("bus fault address not captured");

    bf_shared_a: assert property (
        ar_hs && (rd_off == `FADCP_OFF_BFA) && !BF_EVENT_I ##1 1'b1 |-> ##[0:1]
        (S_AXI_RVALID_O && (S_AXI_RDATA_O == bfa_ff)))
        else $error("bus fault address differs between states");

    coproc_access_control_bank_a: assert property (
        SEC_PRESENT && do_write && awns_ff && (wr_off == `FADCP_OFF_CPAC)
        |=> $stable(coproc_access_control_ff[0]) && S_AXI_BVALID_O)
        else $error("non-secure write changed secure access control");

    fp_primary_a: assert property (
        CE_I && CP_REQ_I && (CP_NUM_I == `FADCP_FP_NUM) && (cp_sel == `FADCP_SEL_SEC) &&
        (coproc_access_control_ff[0][`FADCP_FP_PRI_LSB +: 2] == PRIV_FULL) |=> !CP_FAULT_O)
        else $error("full fp access faulted");

    fp_deny_a: assert property (
        CE_I && CP_REQ_I && (CP_NUM_I == `FADCP_FP_NUM) &&
        (coproc_access_control_ff[cp_sel[1]][`FADCP_FP_PRI_LSB +: 2] == PRIV_DENY) |=> CP_FAULT_O)
        else $error("denied fp access did not fault");

    fp_absent_a: assert property (
        !FP_PRESENT |-> (coproc_access_control_ff[0][`FADCP_FP_SEC_LSB+1:`FADCP_FP_PRI_LSB] == 4'h0) &&
                        (coproc_access_control_ff[1][`FADCP_FP_SEC_LSB+1:`FADCP_FP_PRI_LSB] == 4'h0))
        else $error("fp fields hold bits without an fpu");

    cp_unpriv_a: assert property (
        CE_I && CP_REQ_I && !CP_PRIV_I && !CP_NUM_I[`FADCP_CP_SEL_MSB] &&
        (coproc_access_control_ff[cp_sel[1]][2*CP_NUM_I[2:0] +: 2] == PRIV_PRIVONLY) |=> CP_FAULT_O)
        else $error("unprivileged coprocessor access not faulted");

    absent_cp_a: assert property (
        (coproc_access_control_ff[0] & ~cp_wmask) == `FADCP_ZERO32 && (coproc_access_control_ff[1] & ~cp_wmask) == `FADCP_ZERO32)
        else $error("absent coprocessor field holds bits");

    rsvd_zero_a: assert property (
        ar_hs && (rd_off == `FADCP_OFF_CPAC) |=> (S_AXI_RDATA_O[31:`FADCP_FP_SEC_LSB+2] == 8'h00) &&
        (S_AXI_RDATA_O[`FADCP_FP_PRI_LSB-1:2*`FADCP_NUM_CP] == 4'h0))
        else $error("reserved access-control bits read non-zero");
endmodule : fadcp_top

// ### verif/fadcp_core_model.sv
// processor core model that raises protection, bus and coprocessor events
`timescale 1ns/1ps
module fadcp_core_model (
    input  wire logic        clk_i,
    input  wire logic        fault_i,
    output logic             mpf_event_o,
    output logic [31:0]      mpf_addr_o,
    output logic             mpf_ns_o,
    output logic             bf_event_o,
    output logic [31:0]      bf_addr_o,
    output logic             cp_req_o,
    output logic [3:0]       cp_num_o,
    output logic             cp_priv_o,
    output logic             cp_ns_o
);
    // fp instructions and register accesses all use this number
    localparam logic [3:0] FP_NUM = 4'hA;

    initial begin
        mpf_event_o = 1'b0;
        mpf_addr_o  = 32'h0000_0000;
        mpf_ns_o    = 1'b0;
        bf_event_o  = 1'b0;
        bf_addr_o   = 32'h0000_0000;
        cp_req_o    = 1'b0;
        cp_num_o    = 4'h0;
        cp_priv_o   = 1'b0;
        cp_ns_o     = 1'b0;
    end

    // ----------------------------------------------------------------
    // fault events of a split unaligned access
    // ----------------------------------------------------------------
    task automatic mem_fault(input logic [31:0] req, input logic [1:0] part, input logic ns);
        @(posedge clk_i);
        mpf_event_o <= 1'b1;
        mpf_addr_o  <= req + 32'(part);
        mpf_ns_o    <= ns;
        @(posedge clk_i);
        mpf_event_o <= 1'b0;
        mpf_addr_o  <= ~(req + 32'(part));
        mpf_ns_o    <= ~ns;
    endtask : mem_fault

    task automatic bus_fault(input logic [31:0] req);
        @(posedge clk_i);
        bf_event_o <= 1'b1;
        bf_addr_o  <= req;
        @(posedge clk_i);
        bf_event_o <= 1'b0;
        bf_addr_o  <= ~req;
    endtask : bus_fault

    // ----------------------------------------------------------------
    // one coprocessor access, fault seen the cycle after
    // ----------------------------------------------------------------
    task automatic cp_access(input logic [3:0] num, input logic priv, input logic ns,
                             output logic fault);
        @(posedge clk_i);
        cp_req_o  <= 1'b1;
        cp_num_o  <= num;
        cp_priv_o <= priv;
        cp_ns_o   <= ns;
        @(posedge clk_i);
        cp_req_o  <= 1'b0;
        cp_num_o  <= ~num;
        cp_priv_o <= ~priv;
        #1;
        fault = fault_i;
    endtask : cp_access
endmodule : fadcp_core_model

// ### verif/test_fault_address_and_coproc_access.sv
// self-checking bench of the fault address and coprocessor access block
`timescale 1ns/1ps
`include "fadcp_map.svh"
module test_fault_address_and_coproc_access;
    localparam logic [7:0]  CPI     = 8'h7F;
    localparam logic [31:0] CP_MASK = 32'h00F0_3FFF;
    logic        clk, rst_n, awv, wv, bready, arv, rready, f;
    logic [31:0] awaddr, wdata, araddr, a0, a1, a2, d0, d1;
    logic [2:0]  awprot, arprot;
    logic        awready, wready, bvalid, arready, rvalid, fault;
    logic [1:0]  bresp, rresp, code;
    logic [31:0] rdata, mpf_addr, bf_addr;
    logic        mpf_ev, mpf_ns, bf_ev, cp_req, cp_priv, cp_ns;
    logic [3:0]  cp_num;
    int          miscompares, cmp_count;
    integer      seed;

    fadcp_top #(.CP_IMPL(CPI)) DUT (
        .MCLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
        .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awready), .S_AXI_AWADDR_I(awaddr),
        .S_AXI_AWPROT_I(awprot), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_BVALID_O(bvalid),
        .S_AXI_BREADY_I(bready), .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arv),
        .S_AXI_ARREADY_O(arready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARPROT_I(arprot),
        .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp), .MPF_EVENT_I(mpf_ev), .MPF_ADDR_I(mpf_addr),
        .MPF_NS_I(mpf_ns), .BF_EVENT_I(bf_ev), .BF_ADDR_I(bf_addr), .CP_REQ_I(cp_req),
        .CP_NUM_I(cp_num), .CP_PRIV_I(cp_priv), .CP_NS_I(cp_ns), .CP_FAULT_O(fault));

    fadcp_core_model core (
        .clk_i(clk), .fault_i(fault), .mpf_event_o(mpf_ev), .mpf_addr_o(mpf_addr),
        .mpf_ns_o(mpf_ns), .bf_event_o(bf_ev), .bf_addr_o(bf_addr), .cp_req_o(cp_req),
        .cp_num_o(cp_num), .cp_priv_o(cp_priv), .cp_ns_o(cp_ns));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // compares, verdict and expectations
    // ----------------------------------------------------------------
    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_word

    task automatic chk_bit(input string name, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    function automatic logic exp_fault(input logic [1:0] c, input logic [3:0] n, input logic pr);
        if (n > 4'h7 && n != 4'hA) return 1'b1;
        if (n < 4'h8 && !CPI[n[2:0]]) return 1'b1;
        return (c == 2'h3) ? 1'b0 : (c == 2'h1) ? !pr : 1'b1;
    endfunction : exp_fault

    // ----------------------------------------------------------------
    // register bus master
    // ----------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [2:0] p,
                      input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge clk);
        awv    <= 1'b1;
        awaddr <= {20'h0_0000, a};
        awprot <= p;
        wv     <= 1'b1;
        wdata  <= d;
        bready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (awv && awready) awv <= 1'b0;
            if (wv && wready) wv <= 1'b0;
            if (bready && bvalid) begin
                chk_word("write response", 32'(er), 32'(bresp));
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [2:0] p, input logic [31:0] ed,
                      input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge clk);
        arv    <= 1'b1;
        araddr <= {20'h0_0000, a};
        arprot <= p;
        rready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arv && arready) arv <= 1'b0;
            if (rready && rvalid) begin
                chk_word("read data", ed, rdata);
                chk_word("read response", 32'(er), 32'(rresp));
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : rd

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 32'hcb9b;
        miscompares = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        {awv, wv, bready, arv, rready} = 5'h00;
        {awaddr, wdata, araddr} = {3{32'h0000_0000}};
        {awprot, arprot} = 6'h00;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(12'(i * 4), 3'h0, 32'h0000_0000, `FADCP_RESP_OKAY);
            rd(12'(i * 4), 3'h2, 32'h0000_0000, `FADCP_RESP_OKAY);
        end
        $display("test reset_values done");
        for (int k = 0; k < 8; k++) begin
            a0 = $random(seed);
            a1 = $random(seed);
            a2 = $random(seed);
            core.mem_fault(a0, 2'(k), 1'b0);
            core.mem_fault(a1, 2'(k + 1), 1'b1);
            core.bus_fault(a2);
            rd(`FADCP_OFF_MPFA, 3'h0, a0 + 32'(k % 4), `FADCP_RESP_OKAY);
            rd(`FADCP_OFF_MPFA, 3'h2, a1 + 32'((k + 1) % 4), `FADCP_RESP_OKAY);
            rd(`FADCP_OFF_BFA, 3'h0, a2, `FADCP_RESP_OKAY);
            rd(`FADCP_OFF_BFA, 3'h2, a2, `FADCP_RESP_OKAY);
            rd(`FADCP_OFF_STAT, 3'h0, 32'h0000_0003, `FADCP_RESP_OKAY);
        end
        wr(`FADCP_OFF_STAT, 32'h0000_0003, 3'h0, `FADCP_RESP_OKAY);
        rd(`FADCP_OFF_STAT, 3'h2, 32'h0000_0001, `FADCP_RESP_OKAY);
        $display("test fault_capture done");
        for (int k = 0; k < 8; k++) begin
            d0 = (k == 0) ? 32'hFFFF_FFFF : $random(seed);
            d1 = $random(seed);
            d0[`FADCP_FP_SEC_LSB +: 2] = d0[`FADCP_FP_PRI_LSB +: 2];
            d1[`FADCP_FP_SEC_LSB +: 2] = d1[`FADCP_FP_PRI_LSB +: 2];
            wr(`FADCP_OFF_CPAC, d0, 3'h0, `FADCP_RESP_OKAY);
            wr(`FADCP_OFF_CPAC, d1, 3'h2, `FADCP_RESP_OKAY);
            rd(`FADCP_OFF_CPAC, 3'h0, d0 & CP_MASK, `FADCP_RESP_OKAY);
            rd(`FADCP_OFF_CPAC, 3'h2, d1 & CP_MASK, `FADCP_RESP_OKAY);
        end
        $display("test control_word done");
        for (int c = 0; c < 4; c++) begin
            code = 2'(c);
            wr(`FADCP_OFF_CPAC, {8'h00, code, code, 4'h0, {8{code}}}, 3'h0, 2'h0);
            wr(`FADCP_OFF_CPAC, {8'h00, ~code, ~code, 4'h0, {8{~code}}}, 3'h2, 2'h0);
            for (int n = 0; n < 12; n++) begin
                for (int m = 0; m < 4; m++) begin
                    core.cp_access(4'(n), m[0], m[1], f);
                    chk_bit("cp fault", exp_fault(m[1] ? ~code : code, 4'(n), m[0]), f);
                end
            end
        end
        wr(`FADCP_OFF_CPAC, 32'h0030_0000, 3'h0, `FADCP_RESP_OKAY);
        core.cp_access(4'hA, 1'b0, 1'b0, f);
        chk_bit("fp fault", 1'b0, f);
        $display("test access_check done");
        wr(12'h010, $random(seed), 3'h0, `FADCP_RESP_SLVERR);
        rd(12'h010, 3'h0, 32'h0000_0000, `FADCP_RESP_SLVERR);
        $display("test unmapped done");
        tally_and_finish;
    end

    initial begin
        #100_000;
        miscompares++;
        tally_and_finish;
    end
endmodule : test_fault_address_and_coproc_access
